// ---- tccc_top.sv ----
// tccc_top: count-clock controller, 16-bit up-counter and two
// compare/capture slots of one timer channel, with an APB slave.
// assumes: oscillator ticks, external clock and trigger pins arrive
// asynchronously and are sampled on i_clk (each must stay above two
// i_clk periods per level); i_clk is much faster than all of them.
// Behaviour
// - two-bit selector picks count clock source
// - fast oscillators divide by two to the n
// - slow oscillator divides to 256, code 9 regulated
// - gate bit blocks count clock when zero
// - per slot mode bit: compare or capture
// - match on slot A sets compare A
// - match on B sets flag, clears counter
// - events CCx plus one clocks from zero
// - shadow copies load on compare B event
// - two-bit trigger edge selector per slot
// - selected edge captures counter, sets flag
// - capture while flag set sets overwrite
// - compare-mode slot ignores trigger edges
// - capture-mode slot makes no compare event
// - counter is sixteen-bit up-counter
// - one-shot stops counter on compare B
`timescale 1ns/100ps
`default_nettype none
module tccc_top
    import tccc_pkg::*;
#(
    parameter int CW = 16 // counter width
) (
    input  wire logic          i_clk,          // 20 MHz system clock
    input  wire logic          i_rst_b,        // async reset, active low
    input  wire logic          psel,           // apb select
    input  wire logic          penable,        // apb access phase
    input  wire logic          pwrite,         // apb direction
    input  wire logic [7:0]    paddr,          // apb byte address
    input  wire logic [31:0]   pwdata,         // apb write data
    output logic      [31:0]   prdata,         // apb read data
    output logic               pready,         // apb ready
    output logic               pslverr,        // apb error
    input  wire logic          i_fast_osc_b,   // fast oscillator b
    input  wire logic          i_slow_osc,     // slow oscillator
    input  wire logic          i_fast_osc_a,   // fast oscillator a
    input  wire logic          i_reg_256hz,    // regulated 256 Hz clock
    input  wire logic          i_ext_count_clk,// external count clock pin
    input  wire logic          i_slot_a_trig,  // slot a trigger pin
    input  wire logic          i_slot_b_trig,  // slot b trigger pin
    output logic               o_cmp_a,        // compare a event pulse
    output logic               o_cmp_b,        // compare b event pulse
    output logic               o_irq           // channel interrupt
);
    import tccc_pkg::*;

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic       rst_s1_reg, rst_b;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_b      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b      <= rst_s1_reg;
        end
    end

    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_d_reg, pin_rise;
    assign pin_raw = {i_slot_b_trig, i_slot_a_trig, i_ext_count_clk, i_reg_256hz,
                      i_fast_osc_a, i_slow_osc, i_fast_osc_b};
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_d_reg  <= '0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg  <= pin_s2_reg;
        end
    end
    assign pin_rise = pin_s2_reg & ~pin_d_reg;

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    logic [1:0]    src_sel_reg;
    logic [3:0]    div_sel_reg;
    logic          gate_en_reg, run_reg, one_shot_reg, shadow_en_reg;
    logic          a_mode_reg, b_mode_reg;
    logic [1:0]    a_edge_reg, b_edge_reg;
    logic [CW-1:0] a_val_reg, b_val_reg, a_shadow_reg, b_shadow_reg, count_reg;
    logic [N_FLAGS-1:0] flag_reg, irq_en_reg, flag_set;
    logic          wr, cnt_clr_wr, cmp_b_hit, cap_a, cap_b;

    assign wr = psel && penable && pwrite;
    assign cnt_clr_wr = wr && paddr == RUN_CTRL_OFS && pwdata[CNT_RST_BIT];

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_sel_reg   <= SRC_RST;
            div_sel_reg   <= DIV_RST;
            gate_en_reg   <= 1'b0;
            run_reg       <= 1'b0;
            one_shot_reg  <= 1'b0;
            shadow_en_reg <= 1'b0;
            a_mode_reg    <= 1'b0;
            b_mode_reg    <= 1'b0;
            a_edge_reg    <= EDGE_NONE;
            b_edge_reg    <= EDGE_NONE;
            irq_en_reg    <= '0;
        end else begin
            if (wr && paddr == CLK_CTRL_OFS) begin
                src_sel_reg <= pwdata[CLK_SRC_LSB +: 2];
                div_sel_reg <= pwdata[CLK_DIV_LSB +: 4];
                gate_en_reg <= pwdata[CLK_GATE_BIT];
            end else if (wr && paddr == SLOT_CTRL_OFS) begin
                a_mode_reg <= pwdata[A_MODE_BIT];
                b_mode_reg <= pwdata[B_MODE_BIT];
                a_edge_reg <= pwdata[A_EDGE_LSB +: 2];
                b_edge_reg <= pwdata[B_EDGE_LSB +: 2];
            end else if (wr && paddr == IRQ_EN_OFS) begin
                irq_en_reg <= pwdata[N_FLAGS-1:0];
            end
            if (wr && paddr == RUN_CTRL_OFS) begin
                run_reg       <= pwdata[RUN_BIT];
                one_shot_reg  <= pwdata[ONE_SHOT_BIT];
                shadow_en_reg <= pwdata[SHADOW_BIT];
            end else if (cmp_b_hit && one_shot_reg) begin
                run_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // count clock: source select, divider, gate
    // ------------------------------------------------------------------
    logic          src_tick, cnt_tick;
    logic [13:0]   div_cnt_reg;
    logic [13:0]   div_mask;
    logic          div_legal;

    always_comb begin
        case (src_sel_reg)
            SRC_FAST_B: src_tick = pin_rise[0];
            SRC_SLOW:   src_tick = pin_rise[1];
            SRC_FAST_A: src_tick = pin_rise[2];
            default:    src_tick = pin_rise[4];
        endcase
        div_mask = 14'((15'h0001 << div_sel_reg) - 15'h0001);
        if (src_sel_reg == SRC_SLOW)
            div_legal = div_sel_reg <= DIV_SLOW_256;
        else
            div_legal = div_sel_reg <= DIV_FAST_MAX;
    end

    // the divider counts source ticks; ratio 1/2^n, reserved codes stall
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b)
            div_cnt_reg <= '0;
        else if (src_tick)
            div_cnt_reg <= div_cnt_reg + 14'h0001;
    end

    always_comb begin
        if (src_sel_reg == SRC_EXT)
            cnt_tick = src_tick;
        else if (src_sel_reg == SRC_SLOW && div_sel_reg == DIV_SLOW_256)
            cnt_tick = pin_rise[3];
        else
            cnt_tick = div_legal && src_tick &&
                       (div_cnt_reg & div_mask) == div_mask;
        cnt_tick = cnt_tick && gate_en_reg && run_reg;
    end

    // ------------------------------------------------------------------
    // counter and compare
    // ------------------------------------------------------------------
    logic [CW-1:0] a_ref, b_ref;
    logic          cmp_a_hit;
    assign a_ref = shadow_en_reg ? a_shadow_reg : a_val_reg;
    assign b_ref = shadow_en_reg ? b_shadow_reg : b_val_reg;
    // a match is judged on the count held when a count clock arrives,
    // so the event lands CCx+1 clocks after counting from zero
    assign cmp_a_hit = cnt_tick && !a_mode_reg && count_reg == a_ref;
    assign cmp_b_hit = cnt_tick && !b_mode_reg && count_reg == b_ref;

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b)
            count_reg <= '0;
        else if (cnt_clr_wr || cmp_b_hit)
            count_reg <= '0;
        else if (cnt_tick)
            count_reg <= count_reg + CW'(1);
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_shadow_reg <= CMP_RST;
            b_shadow_reg <= CMP_RST;
        end else if (cmp_b_hit) begin
            a_shadow_reg <= a_val_reg;
            b_shadow_reg <= b_val_reg;
        end
    end

    // ------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                      input logic was);
        edge_hit = (sel[0] && now && !was) || (sel[1] && !now && was);
    endfunction

    // captures are taken only while counting (run set)
    assign cap_a = a_mode_reg && run_reg &&
                   edge_hit(a_edge_reg, pin_s2_reg[5], pin_d_reg[5]);
    assign cap_b = b_mode_reg && run_reg &&
                   edge_hit(b_edge_reg, pin_s2_reg[6], pin_d_reg[6]);

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            a_val_reg <= CMP_RST;
            b_val_reg <= CMP_RST;
        end else begin
            // a capture outranks a same-cycle software write
            if (cap_a)
                a_val_reg <= count_reg;
            else if (wr && paddr == SLOT_A_OFS)
                a_val_reg <= pwdata[CW-1:0];
            if (cap_b)
                b_val_reg <= count_reg;
            else if (wr && paddr == SLOT_B_OFS)
                b_val_reg <= pwdata[CW-1:0];
        end
    end

    // ------------------------------------------------------------------
    // flags and interrupt; a hardware set wins over a clear
    // ------------------------------------------------------------------
    always_comb begin
        flag_set          = '0;
        flag_set[F_CMP_A] = cmp_a_hit;
        flag_set[F_CMP_B] = cmp_b_hit;
        flag_set[F_CAP_A] = cap_a;
        flag_set[F_CAP_B] = cap_b;
        flag_set[F_OVW]   = (cap_a && flag_reg[F_CAP_A]) ||
                            (cap_b && flag_reg[F_CAP_B]);
    end

    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= '0;
            o_irq    <= 1'b0;
            o_cmp_a  <= 1'b0;
            o_cmp_b  <= 1'b0;
        end else begin
            if (wr && paddr == FLAG_OFS)
                flag_reg <= (flag_reg & ~pwdata[N_FLAGS-1:0]) | flag_set;
            else
                flag_reg <= flag_reg | flag_set;
            o_irq   <= |(flag_reg & irq_en_reg);
            o_cmp_a <= cmp_a_hit;
            o_cmp_b <= cmp_b_hit;
        end
    end

    // ------------------------------------------------------------------
    // apb read path: zero-wait, unmapped reads zero with pslverr
    // ------------------------------------------------------------------
    logic [31:0] rd_next;
    logic        map_hit;
    always_comb begin
        rd_next = 32'h0000_0000;
        map_hit = 1'b1;
        if (paddr == CLK_CTRL_OFS)
            rd_next = 32'({gate_en_reg, div_sel_reg, 2'h0, src_sel_reg});
        else if (paddr == RUN_CTRL_OFS)
            rd_next = 32'({shadow_en_reg, one_shot_reg, 1'b0, run_reg});
        else if (paddr == SLOT_CTRL_OFS)
            rd_next = 32'({b_edge_reg, a_edge_reg, 2'h0, b_mode_reg, a_mode_reg});
        else if (paddr == SLOT_A_OFS)
            rd_next = 32'(a_val_reg);
        else if (paddr == SLOT_B_OFS)
            rd_next = 32'(b_val_reg);
        else if (paddr == COUNT_OFS)
            rd_next = 32'(count_reg);
        else if (paddr == FLAG_OFS)
            rd_next = 32'(flag_reg);
        else if (paddr == IRQ_EN_OFS)
            rd_next = 32'(irq_en_reg);
        else
            map_hit = 1'b0;
    end

    // answer registered in the setup cycle, ready in the access phase
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_next : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- tccc_pkg.sv ----
// tccc_pkg: register map, field layout and reset values of the timer
// count-clock and compare/capture channel; shared by design and bench.
package tccc_pkg;
    // -----------------------------------------------------------------
    // register byte offsets (one aligned word each)
    // -----------------------------------------------------------------
    localparam logic [7:0] CLK_CTRL_OFS   = 8'h00; // clock_control_reg
    localparam logic [7:0] RUN_CTRL_OFS   = 8'h04; // run, reset, one-shot, shadow en
    localparam logic [7:0] SLOT_CTRL_OFS  = 8'h08; // slot_control_reg
    localparam logic [7:0] SLOT_A_OFS     = 8'h0C; // slot_a_value_reg
    localparam logic [7:0] SLOT_B_OFS     = 8'h10; // slot_b_value_reg
    localparam logic [7:0] COUNT_OFS      = 8'h14; // counter, read only
    localparam logic [7:0] FLAG_OFS       = 8'h18; // flags, write 1 to clear
    localparam logic [7:0] IRQ_EN_OFS     = 8'h1C; // interrupt enables
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int CLK_SRC_LSB  = 0;  // count_clock_source_sel [1:0]
    localparam int CLK_DIV_LSB  = 4;  // count_clock_divider_sel [3:0]
    localparam int CLK_GATE_BIT = 8;  // count_clock_gate_en
    localparam int RUN_BIT      = 0;
    localparam int CNT_RST_BIT  = 1;  // write 1 clears counter
    localparam int ONE_SHOT_BIT = 2;  // one_shot_select
    localparam int SHADOW_BIT   = 3;  // compare_shadow_en
    localparam int A_MODE_BIT   = 0;  // slot_a_mode
    localparam int B_MODE_BIT   = 1;  // slot_b_mode
    localparam int A_EDGE_LSB   = 4;  // slot_a_edge_sel
    localparam int B_EDGE_LSB   = 6;  // slot_b_edge_sel
    // flag / enable bit order
    localparam int F_CMP_A = 0;
    localparam int F_CMP_B = 1;
    localparam int F_CAP_A = 2;
    localparam int F_CAP_B = 3;
    localparam int F_OVW   = 4;
    localparam int N_FLAGS = 5;
    // -----------------------------------------------------------------
    // encodings and reset values
    // -----------------------------------------------------------------
    localparam logic [1:0] SRC_FAST_B = 2'h0;
    localparam logic [1:0] SRC_SLOW   = 2'h1;
    localparam logic [1:0] SRC_FAST_A = 2'h2;
    localparam logic [1:0] SRC_EXT    = 2'h3;
    localparam logic [3:0] DIV_FAST_MAX = 4'hE;
    localparam logic [3:0] DIV_SLOW_MAX = 4'h8;
    localparam logic [3:0] DIV_SLOW_256 = 4'h9;
    localparam logic [1:0] EDGE_NONE  = 2'h0;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_FALL  = 2'h2;
    localparam logic [1:0] EDGE_BOTH  = 2'h3;
    localparam logic [1:0] SRC_RST    = 2'h0;
    localparam logic [3:0] DIV_RST    = 4'h0;
    localparam logic [15:0] CMP_RST   = 16'hFFFF;
endpackage

// ---- tccc_monitor.sv ----
// tccc_monitor: concurrent checks on the ports of tccc_top.
// assumes: one clock domain; attached to tccc_top by the bind below.
`timescale 1ns/100ps
`default_nettype none
module tccc_monitor (
    input wire logic        i_clk,   // system clock
    input wire logic        i_rst_b, // reset, active low
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb enable
    input wire logic        pwrite,  // apb direction
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr, // apb error
    input wire logic        o_cmp_a, // compare a pulse
    input wire logic        o_cmp_b, // compare b pulse
    input wire logic        o_irq    // channel interrupt
);
    import tccc_pkg::*;
    wire acc    = psel && penable;
    wire mapped = paddr <= IRQ_EN_OFS && paddr[1:0] == 2'h0;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------------
    // enables cleared: irq must drop two cycles later
    // ----------------------------------------------
    sequence s_en_off;
        acc && pwrite && paddr == IRQ_EN_OFS && pwdata[4:0] == 5'h00;
    endsequence
    sequence s_irq_gone;
        ##1 !o_irq;
    endsequence
    a_irq_en_off: assert property (s_en_off |=> s_irq_gone)
        else $error("irq stays up after enables cleared");
    a_ready_access: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_ready_idle: assert property (!acc |-> !pready)
        else $error("pready high outside access phase");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not follow the address map");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
        else $error("prdata nonzero outside a read");
    // ticks are at least four clocks apart, so a pulse is followed by quiet
    a_cmp_a_pulse: assert property (o_cmp_a |=> !o_cmp_a [*3])
        else $error("compare a pulse too long");
    a_cmp_b_pulse: assert property (o_cmp_b |=> !o_cmp_b [*3])
        else $error("compare b pulse too long");
endmodule
bind tccc_top tccc_monitor mon_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_cmp_a(o_cmp_a), .o_cmp_b(o_cmp_b), .o_irq(o_irq)
);
`default_nettype wire

// ---- tccc_pins_model.sv ----
// tccc_pins_model: oscillators, external count clock and trigger pins.
// assumes: i_clk is the system clock; periods are in i_clk cycles.
`timescale 1ns/100ps
`default_nettype none
module tccc_pins_model (
    input  wire logic i_clk,        // system clock
    input  wire logic i_ext_run,    // external clock burst on
    input  wire logic i_lvl_a,      // wanted slot a trigger level
    input  wire logic i_lvl_b,      // wanted slot b trigger level
    output logic      o_fast_osc_b, // period 8
    output logic      o_slow_osc,   // period 12
    output logic      o_fast_osc_a, // period 6
    output logic      o_reg_256hz,  // period 10
    output logic      o_ext_clk,    // period 14, low when idle
    output logic      o_trig_a,     // slot a trigger pin
    output logic      o_trig_b      // slot b trigger pin
);
    logic [31:0] cyc  = 32'h0;
    logic [31:0] ecyc = 32'h0;
    always @(posedge i_clk) begin
        cyc  <= cyc + 32'h1;
        ecyc <= i_ext_run ? ecyc + 32'h1 : 32'h0;
    end
    // distinct periods so a wrong source pick shows as a wrong period
    assign o_fast_osc_b = cyc[2];
    assign o_slow_osc   = (cyc % 32'hC) >= 32'h6;
    assign o_fast_osc_a = (cyc % 32'h6) >= 32'h3;
    assign o_reg_256hz  = (cyc % 32'hA) >= 32'h5;
    // stands still between bursts so the counter can be frozen
    assign o_ext_clk    = i_ext_run && (ecyc % 32'hE) >= 32'h7;
    // the bench holds each level at least eight clocks, more than two i_clk periods
    assign o_trig_a     = i_lvl_a;
    assign o_trig_b     = i_lvl_b;
endmodule
`default_nettype wire

// ---- tb_timer_clock_compare_capture.sv ----
// tb_timer_clock_compare_capture: self-checking bench for tccc_top.
// assumes: tccc_pins_model supplies every source clock and trigger pin.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_clock_compare_capture;
    import tccc_pkg::*;
    logic        i_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rd_err, o_cmp_a, o_cmp_b, o_irq;
    logic        osc_fb, osc_s, osc_fa, osc_256, ext_clk, trig_a, trig_b;
    logic        ext_run = 1'b0, lvl_a = 1'b0, lvl_b = 1'b0;
    int          n_errors = 0, n_tests = 0, n_cmp_a = 0, t;
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (o_cmp_a === 1'b1) n_cmp_a <= n_cmp_a + 1;
    tccc_top dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_fast_osc_b(osc_fb), .i_slow_osc(osc_s), .i_fast_osc_a(osc_fa),
        .i_reg_256hz(osc_256), .i_ext_count_clk(ext_clk), .i_slot_a_trig(trig_a),
        .i_slot_b_trig(trig_b), .o_cmp_a(o_cmp_a), .o_cmp_b(o_cmp_b), .o_irq(o_irq)
    );
    tccc_pins_model pins_u (
        .i_clk(i_clk), .i_ext_run(ext_run), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b),
        .o_fast_osc_b(osc_fb), .o_slow_osc(osc_s), .o_fast_osc_a(osc_fa),
        .o_reg_256hz(osc_256), .o_ext_clk(ext_clk), .o_trig_a(trig_a), .o_trig_b(trig_b)
    );
    // ----------------------------------------------
    // shared tasks
    // ----------------------------------------------
    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_ev(input logic on_b, input int lim);
        t = 0;
        do begin
            @(posedge i_clk);
            t++;
        end while ((on_b ? o_cmp_b : o_cmp_a) !== 1'b1 && t < lim);
    endtask
    task automatic restart(input logic [31:0] ck, ca, cb, run);
        apb(1'b1, RUN_CTRL_OFS, 32'h0);
        apb(1'b1, CLK_CTRL_OFS, ck);
        apb(1'b1, SLOT_A_OFS, ca);
        repeat (100) @(posedge i_clk);
        apb(1'b1, SLOT_B_OFS, cb);
        apb(1'b1, RUN_CTRL_OFS, run);
    endtask
    // ----------------------------------------------
    // scenarios
    // ----------------------------------------------
    task automatic t_reset;
        apb(1'b0, CLK_CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "clock control reset");
        apb(1'b0, SLOT_CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "slot control reset");
        apb(1'b0, SLOT_B_OFS, 32'h0);
        chk(rd, {16'h0, CMP_RST}, "slot b reset");
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0, "unmapped read data");
        chk({31'h0, rd_err}, 32'h1, "unmapped error");
    endtask
    task automatic t_period;
        logic [8:0] cfg [10] = '{9'h100, 9'h120, 9'h112, 9'h101, 9'h131, 9'h191, 9'h103,
                                 9'h1F0, 9'h1A1, 9'h000};
        int per [10] = '{8, 32, 12, 12, 96, 10, 14, 0, 0, 0};
        ext_run <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            restart({23'h0, cfg[i]}, 32'h0, 32'h0, 32'h3);
            wait_ev(1'b1, 400);
            if (per[i] != 0) wait_ev(1'b1, 400);
            chk(t, per[i] == 0 ? 400 : per[i], "tick period");
        end
    endtask
    task automatic t_compare;
        apb(1'b1, IRQ_EN_OFS, 32'h3);
        apb(1'b1, SLOT_CTRL_OFS, 32'h0);
        apb(1'b1, FLAG_OFS, 32'h1F);
        restart(32'h100, 32'h1, 32'h3, 32'h3);
        wait_ev(1'b1, 400);
        wait_ev(1'b0, 100);
        chk(t, 16, "compare b to compare a");
        wait_ev(1'b1, 100);
        chk(t, 16, "compare a to compare b");
        apb(1'b1, RUN_CTRL_OFS, 32'h0);
        apb(1'b0, FLAG_OFS, 32'h0);
        chk(rd, 32'h3, "compare flags");
        chk({31'h0, o_irq}, 32'h1, "irq with flags");
        apb(1'b1, FLAG_OFS, 32'h3);
        repeat (3) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h0, "irq after clear");
    endtask
    task automatic t_oneshot;
        restart(32'h100, 32'hFFFF, 32'h2, 32'h7);
        wait_ev(1'b1, 400);
        apb(1'b0, RUN_CTRL_OFS, 32'h0);
        chk(rd & 32'h1, 32'h0, "run after one-shot");
        apb(1'b0, COUNT_OFS, 32'h0);
        chk(rd, 32'h0, "count after compare b");
        wait_ev(1'b1, 200);
        chk(t, 200, "second compare b");
    endtask
    // shadows still hold the pair loaded by the one-shot compare b
    task automatic t_shadow;
        int n_a;
        restart(32'h100, 32'h1, 32'h5, 32'hB);
        apb(1'b0, CLK_CTRL_OFS, 32'h0);
        chk(rd, 32'h100, "clock control readback");
        n_a = n_cmp_a;
        wait_ev(1'b1, 400);
        chk(n_cmp_a, n_a, "compare a before shadow load");
        wait_ev(1'b0, 100);
        chk(t, 16, "shadow compare a");
        wait_ev(1'b1, 100);
        chk(t, 32, "shadow compare b");
    endtask
    task automatic t_capture;
        logic [4:0] rise, fall;
        ext_run <= 1'b0;
        restart(32'h103, 32'h1234, 32'hFFFF, 32'h3);
        apb(1'b1, IRQ_EN_OFS, 32'h10);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, SLOT_CTRL_OFS, {24'h0, 2'h3, c[1:0], 4'h1});
            apb(1'b1, FLAG_OFS, 32'h1F);
            rise = c[0] ? 5'h04 : 5'h00;
            fall = !c[1] ? 5'h00 : (c == 3 ? 5'h14 : 5'h04);
            lvl_a <= 1'b1;
            lvl_b <= 1'b1;
            repeat (8) @(posedge i_clk);
            apb(1'b0, FLAG_OFS, 32'h0);
            chk(rd, {27'h0, rise}, "flags after rise");
            if (c != 3) apb(1'b1, FLAG_OFS, 32'h1F);
            lvl_a <= 1'b0;
            lvl_b <= 1'b0;
            repeat (8) @(posedge i_clk);
            apb(1'b0, FLAG_OFS, 32'h0);
            chk(rd, {27'h0, fall}, "flags after fall");
        end
        chk({31'h0, o_irq}, 32'h1, "overwrite irq");
        apb(1'b0, SLOT_A_OFS, 32'h0);
        chk(rd, 32'h0, "captured count");
        t = n_cmp_a;
        ext_run <= 1'b1;
        repeat (100) @(posedge i_clk);
        chk(n_cmp_a, t, "compare a in capture mode");
        apb(1'b1, IRQ_EN_OFS, 32'h0);
        repeat (2) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h0, "irq with enables off");
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_period();
        t_compare();
        t_oneshot();
        t_shadow();
        t_capture();
        end_sim();
    end
    initial begin
        repeat (40000) @(posedge i_clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
